// *** core/msh_ctrl_regs.sv ***
// msh_ctrl_regs: mode/supply and hardware-behaviour control registers behind spi
// assumes mode machine, regulators and watchdog sit outside and report events here
`timescale 1ns/10ps
`default_nettype none
// Operation
// RULE_01: mode bits 7:6 normal sleep stop softreset
// RULE_02: soft reset drives reset low unless selected
// RULE_03: reserved bits always read zero
// RULE_04: supply bits 4:3 off normal normstop always
// RULE_05: overvoltage sets flag, optionally requests restart
// RULE_06: threshold bits 1:0 pick four levels
// RULE_07: no direct stop to sleep by spi
// RULE_08: restart entry sets mode to normal
// RULE_09: restart or overtemperature turns supply off
// RULE_10: write reply returns previous contents
// RULE_11: force bit activates failure outputs
// RULE_12: watchdog fail count one or two
// RULE_13: byte access, bit 7 selects write
// RULE_14: software writes zero to reserved bits
// RULE_15: force clear keeps failure; restart clears force
// RULE_16: restart keeps unchanged bits
// RULE_17: restart clears bits 7:2, keeps threshold
module msh_ctrl_regs
   import msh_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // spi pins
   input  wire logic       spi_csn_b,
   input  wire logic       spi_clk,
   input  wire logic       spi_mosi,
   output logic            spi_miso,
   // system events
   input  wire logic       restart_entry,
   input  wire logic       overtemp_event,
   input  wire logic       main_ov_detect,
   input  wire logic       main_ov_flag_clear,
   input  wire logic       failure_flag,
   input  wire logic       fail_safe_mode,
   input  wire logic       wd_trigger_fail,
   input  wire logic       wd_fail_clear,
   // mode, supply, overvoltage, failure and watchdog outputs
   output msh_mode_type    op_mode,
   output logic            soft_reset_req,
   output logic            reset_output_b,
   output logic            secondary_supply_on,
   output logic [1:0]      reset_threshold_select,
   output logic            main_overvoltage_flag,
   output logic            ov_mode_change_req,
   output logic            failure_outputs,
   output logic            wd_fail_mode_req
);
   msh_frame_if frm ();

   logic [7:0]   mode_supply_q;
   logic [7:0]   hw_behav_q;
   logic [7:0]   ms_wr;
   logic         wr_ms;
   logic         wr_hw;
   logic         soft_q;
   logic         ov_flag_q;
   logic         ov_req_q;
   logic         wd_req_q;
   logic [1:0]   wd_cnt_q;
   msh_mode_type cur_mode;
   msh_mode_type new_mode;

   msh_spi_shift u_shift
   (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .spi_csn_b (spi_csn_b),
      .spi_clk   (spi_clk),
      .spi_mosi  (spi_mosi),
      .spi_miso  (spi_miso),
      .frm       (frm)
   );

   // ------------------------------------------------------------
   // access decode
   // ------------------------------------------------------------
   assign wr_ms = frm.frame_done & frm.wr_req & (frm.addr == MSH_ADDR_MODE_SUPPLY); // see RULE_13
   assign wr_hw = frm.frame_done & frm.wr_req & (frm.addr == MSH_ADDR_HW_BEHAV);    // see RULE_13

   // reply is the stored value, captured before any write lands
   always_comb
   begin
      unique case (frm.addr)                                           // see RULE_10
         MSH_ADDR_MODE_SUPPLY: frm.rdata = mode_supply_q & MSH_MODE_SUPPLY_MASK; // see RULE_03
         MSH_ADDR_HW_BEHAV:    frm.rdata = hw_behav_q & MSH_HW_BEHAV_MASK;      // see RULE_03
         default:              frm.rdata = 8'h00;
      endcase
   end

   // ------------------------------------------------------------
   // mode and supply register
   // ------------------------------------------------------------
   assign cur_mode = msh_mode_type'(mode_supply_q[MSH_MODE_HI:MSH_MODE_LO]);
   assign new_mode = msh_mode_type'(frm.wdata[MSH_MODE_HI:MSH_MODE_LO]);

   always_comb
   begin
      ms_wr = frm.wdata & MSH_MODE_SUPPLY_MASK;                        // see RULE_14
      if (cur_mode == MSH_MODE_STOP && new_mode == MSH_MODE_SLEEP)
         ms_wr[MSH_MODE_HI:MSH_MODE_LO] = MSH_MODE_STOP;                // see RULE_07
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         mode_supply_q <= MSH_MODE_SUPPLY_RESET;
      else if (restart_entry)
      begin
         // mode to normal, supply off, keep threshold
         mode_supply_q <= mode_supply_q & MSH_MODE_SUPPLY_KEEP;        // see RULE_08, RULE_16, RULE_17
      end
      else
      begin
         if (wr_ms)
            mode_supply_q <= ms_wr;                                    // see RULE_01
         if (overtemp_event)
            mode_supply_q[MSH_SUP_HI:MSH_SUP_LO] <= MSH_SUP_OFF;        // see RULE_09
      end
   end

   // soft reset request pulses for one clock cycle; stored mode stays soft, op_mode reports it as normal
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         soft_q <= 1'b0;
      else
         soft_q <= wr_ms & (new_mode == MSH_MODE_SOFT);                // see RULE_01
   end

   // ------------------------------------------------------------
   // hardware behaviour register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         hw_behav_q <= MSH_HW_BEHAV_RESET;
      else if (restart_entry)
         hw_behav_q <= hw_behav_q & MSH_HW_BEHAV_KEEP;                 // see RULE_15, RULE_16
      else if (wr_hw)
         hw_behav_q <= frm.wdata & MSH_HW_BEHAV_MASK;                  // see RULE_14
   end

   // ------------------------------------------------------------
   // overvoltage flag and action
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         ov_flag_q <= 1'b0;
      else if (main_ov_detect)
         ov_flag_q <= 1'b1;                                            // see RULE_05
      else if (main_ov_flag_clear)
         ov_flag_q <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         ov_req_q <= 1'b0;
      else
         ov_req_q <= main_ov_detect & mode_supply_q[MSH_OV_ACT_BIT];   // see RULE_05
   end

   // ------------------------------------------------------------
   // watchdog failure count
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b || wd_fail_clear)
         wd_cnt_q <= 2'h0;
      else if (wd_trigger_fail && wd_cnt_q != 2'h2)
         wd_cnt_q <= wd_cnt_q + 2'h1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         wd_req_q <= 1'b0;
      else if (hw_behav_q[MSH_WD_CFG_BIT])
         wd_req_q <= wd_trigger_fail;                                  // see RULE_12
      else
         wd_req_q <= wd_trigger_fail & (wd_cnt_q != 2'h0);             // see RULE_12
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   always_comb
   begin
      unique case (msh_sup_type'(mode_supply_q[MSH_SUP_HI:MSH_SUP_LO])) // see RULE_04
         MSH_SUP_OFF:       secondary_supply_on = 1'b0;
         MSH_SUP_NORMAL:    secondary_supply_on = (cur_mode == MSH_MODE_NORMAL);
         MSH_SUP_NORM_STOP: secondary_supply_on = (cur_mode == MSH_MODE_NORMAL) ||
                                                  (cur_mode == MSH_MODE_STOP);
         MSH_SUP_ALWAYS:    secondary_supply_on = ~fail_safe_mode;
      endcase
   end

   assign op_mode                = (cur_mode == MSH_MODE_SOFT) ? MSH_MODE_NORMAL : cur_mode;
   assign soft_reset_req         = soft_q;
   assign reset_output_b         = ~(soft_q & ~hw_behav_q[MSH_SRO_SEL_BIT]); // see RULE_02
   assign reset_threshold_select = mode_supply_q[MSH_RT_HI:MSH_RT_LO];       // see RULE_06
   assign main_overvoltage_flag  = ov_flag_q;
   assign ov_mode_change_req     = ov_req_q;
   assign failure_outputs        = hw_behav_q[MSH_FO_FORCE_BIT] | failure_flag; // see RULE_11, RULE_15
   assign wd_fail_mode_req       = wd_req_q;
endmodule
`default_nettype wire

// *** core/msh_frame_if.sv ***
// msh_frame_if: decoded spi frame passed from the shifter to the register bank
// assumes one clock domain, frame strobe lasts one cycle
`timescale 1ns/10ps
`default_nettype none
interface msh_frame_if;
   logic       frame_done;
   logic       wr_req;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       rd_load;

   modport shifter
   (
      output frame_done,
      output wr_req,
      output addr,
      output wdata,
      input  rdata,
      output rd_load
   );
   modport bank
   (
      input  frame_done,
      input  wr_req,
      input  addr,
      input  wdata,
      output rdata,
      input  rd_load
   );
endinterface
`default_nettype wire

// *** core/msh_pkg.sv ***
// msh_pkg: constants and types for the mode/supply and hardware-behaviour control bank
// assumes an spi frame of 16 bits: access bit, 7-bit address, then data byte
package msh_pkg;

   // ------------------------------------------------------------
   // register addresses
   // ------------------------------------------------------------
   localparam logic [6:0] MSH_ADDR_MODE_SUPPLY = 7'h01;
   localparam logic [6:0] MSH_ADDR_HW_BEHAV    = 7'h02;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int MSH_MODE_HI      = 7;
   localparam int MSH_MODE_LO      = 6;
   localparam int MSH_SUP_HI       = 4;
   localparam int MSH_SUP_LO       = 3;
   localparam int MSH_OV_ACT_BIT   = 2;
   localparam int MSH_RT_HI        = 1;
   localparam int MSH_RT_LO        = 0;
   localparam int MSH_SRO_SEL_BIT  = 6;
   localparam int MSH_FO_FORCE_BIT = 5;
   localparam int MSH_WD_CFG_BIT   = 0;
   localparam int MSH_WR_BIT       = 7;

   // ------------------------------------------------------------
   // writable masks, reset and restart values
   // ------------------------------------------------------------
   localparam logic [7:0] MSH_MODE_SUPPLY_MASK  = 8'hdf;
   localparam logic [7:0] MSH_HW_BEHAV_MASK     = 8'h61;
   localparam logic [7:0] MSH_MODE_SUPPLY_RESET = 8'h00;
   localparam logic [7:0] MSH_HW_BEHAV_RESET    = 8'h00;
   localparam logic [7:0] MSH_MODE_SUPPLY_KEEP  = 8'h03;
   localparam logic [7:0] MSH_HW_BEHAV_KEEP     = 8'h41;

   // ------------------------------------------------------------
   // encodings
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      MSH_MODE_NORMAL = 2'h0,
      MSH_MODE_SLEEP  = 2'h1,
      MSH_MODE_STOP   = 2'h2,
      MSH_MODE_SOFT   = 2'h3
   } msh_mode_type;

   typedef enum logic [1:0]
   {
      MSH_SUP_OFF       = 2'h0,
      MSH_SUP_NORMAL    = 2'h1,
      MSH_SUP_NORM_STOP = 2'h2,
      MSH_SUP_ALWAYS    = 2'h3
   } msh_sup_type;

   localparam int MSH_FRAME_BITS = 16;

endpackage

// *** core/msh_spi_shift.sv ***
// msh_spi_shift: spi slave shifter, msb first, mode 0 style sampling
// assumes spi pins are synchronous to ref_clk and sampled here
`timescale 1ns/10ps
`default_nettype none
module msh_spi_shift
   import msh_pkg::*;
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_b,
   // spi pins
   input  wire logic spi_csn_b,
   input  wire logic spi_clk,
   input  wire logic spi_mosi,
   output logic      spi_miso,
   // frame to bank
   msh_frame_if.shifter frm
);
   logic [15:0] rx_q;
   logic [4:0]  cnt_q;
   logic [7:0]  tx_q;
   logic        clk_q;
   logic        rise;
   logic        fall;

   assign rise = spi_clk & ~clk_q & ~spi_csn_b;
   assign fall = ~spi_clk & clk_q & ~spi_csn_b;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         clk_q <= 1'b0;
      else
         clk_q <= spi_clk;
   end

   // ------------------------------------------------------------
   // receive shift and bit count
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b || spi_csn_b)
      begin
         rx_q  <= 16'h0000;
         cnt_q <= 5'h00;
      end
      else if (rise)
      begin
         rx_q  <= {rx_q[14:0], spi_mosi};
         cnt_q <= cnt_q + 5'h01;
      end
   end

   // full 16 bits then chip select release ends the frame
   assign frm.frame_done = spi_csn_b & (cnt_q == 5'(MSH_FRAME_BITS)) & rst_b;
   assign frm.wr_req     = rx_q[8 + MSH_WR_BIT];
   // address still sits low in the shifter while the reply is fetched
   assign frm.addr       = (cnt_q == 5'h08) ? rx_q[6:0] : rx_q[14:8];
   assign frm.wdata      = rx_q[7:0];
   // data byte reply is loaded once the address byte is in
   assign frm.rd_load    = fall & (cnt_q == 5'h08);

   // ------------------------------------------------------------
   // transmit: old contents shifted out in the data byte
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b || spi_csn_b)
         tx_q <= 8'h00;
      else if (frm.rd_load)
         tx_q <= frm.rdata;
      else if (fall && cnt_q > 5'h08)
         tx_q <= {tx_q[6:0], 1'b0};
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         spi_miso <= 1'b0;
      else
         spi_miso <= tx_q[7];
   end
endmodule
`default_nettype wire

// *** dv/msh_ctrl_regs_asserts.sv ***
// msh_ctrl_regs_asserts: port-level checks for the control register bank
// assumes one clock domain, reset synchronous and active low
`timescale 1ns/10ps
`default_nettype none
module msh_ctrl_regs_asserts
   import msh_pkg::*;
(
   // clock and reset
   input wire logic         ref_clk,
   input wire logic         rst_b,
   // system events
   input wire logic         restart_entry,
   input wire logic         overtemp_event,
   input wire logic         main_ov_detect,
   input wire logic         failure_flag,
   input wire logic         wd_trigger_fail,
   // outputs
   input wire msh_mode_type op_mode,
   input wire logic         soft_reset_req,
   input wire logic         reset_output_b,
   input wire logic         secondary_supply_on,
   input wire logic [1:0]   reset_threshold_select,
   input wire logic         main_overvoltage_flag,
   input wire logic         ov_mode_change_req,
   input wire logic         failure_outputs,
   input wire logic         wd_fail_mode_req
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_ov_flag_set: assert property (main_ov_detect |=> main_overvoltage_flag)
      else $error("overvoltage flag not set");
   a_ov_req_cause: assert property (ov_mode_change_req |-> $past(main_ov_detect))
      else $error("mode change request without overvoltage");
   a_soft_pulse: assert property (soft_reset_req |=> !soft_reset_req)
      else $error("soft reset request longer than one cycle");
   a_reset_out_cause: assert property (!reset_output_b |-> soft_reset_req)
      else $error("reset output low outside soft reset");
   a_stop_no_sleep: assert property (op_mode == MSH_MODE_STOP |=> op_mode != MSH_MODE_SLEEP)
      else $error("stop went straight to sleep");
   a_restart_normal: assert property (restart_entry |=> op_mode == MSH_MODE_NORMAL)
      else $error("mode not normal after restart");
   a_supply_off: assert property (restart_entry || overtemp_event |=> !secondary_supply_on)
      else $error("secondary supply still on");
   a_fail_drives_fo: assert property (failure_flag |-> failure_outputs)
      else $error("failure outputs idle during failure");
   a_restart_force: assert property (restart_entry ##1 !failure_flag |-> !failure_outputs)
      else $error("force bit survived restart");
   a_rt_kept: assert property (restart_entry |=> $stable(reset_threshold_select))
      else $error("threshold changed by restart");
   a_wd_req_cause: assert property (wd_fail_mode_req |-> $past(wd_trigger_fail))
      else $error("watchdog request without trigger failure");

   c_soft_low: cover property (soft_reset_req && !reset_output_b);
   c_ov_req: cover property (ov_mode_change_req);
   c_wd_req: cover property (wd_fail_mode_req);
endmodule
bind msh_ctrl_regs msh_ctrl_regs_asserts i_chk (.ref_clk, .rst_b, .restart_entry,
   .overtemp_event, .main_ov_detect, .failure_flag, .wd_trigger_fail, .op_mode,
   .soft_reset_req, .reset_output_b, .secondary_supply_on, .reset_threshold_select,
   .main_overvoltage_flag, .ov_mode_change_req, .failure_outputs, .wd_fail_mode_req);
`default_nettype wire

// *** dv/msh_spi_master.sv ***
// msh_spi_master: behavioural spi master standing in for the microcontroller
// assumes spi pins sampled by ref_clk, clock idles low between frames
`timescale 1ns/10ps
`default_nettype none
module msh_spi_master
(
   // clock
   input wire logic   ref_clk,
   // spi pins
   output logic       spi_csn_b,
   output logic       spi_clk,
   output logic       spi_mosi,
   input wire logic   spi_miso,
   // reply byte
   output logic       rep_v,
   output logic [7:0] rep
);
   // ------------------------------------------------------------
   // frame transfer
   // ------------------------------------------------------------
   initial
   begin
      spi_csn_b = 1'b1;
      spi_clk = 1'b0;
      spi_mosi = 1'b0;
      rep_v = 1'b0;
      rep = 8'h00;
   end

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // access bit, address, then data byte, msb first
   task automatic xfer(input logic [15:0] f);
      logic [7:0] r;
      step(1);
      spi_csn_b = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         spi_mosi = f[i];
         step(3);
         spi_clk = 1'b1;
         if (i < 8)
            r[i] = spi_miso;
         step(3);
         spi_clk = 1'b0;
      end
      step(2);
      spi_csn_b = 1'b1;
      spi_mosi = ~spi_mosi;
      rep = r;
      rep_v = 1'b1;
      step(1);
      rep_v = 1'b0;
      step(2);
   endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// tb: self-checking bench for the control register bank
// assumes msh_spi_master as the far side, replies checked through a queue
`timescale 1ns/10ps
`default_nettype none
module tb;
   import msh_pkg::*;
   // ------------------------------------------------------------
   // signals and instances
   // ------------------------------------------------------------
   logic ref_clk = 1'b0, rst_b = 1'b0, restart_entry = 1'b0, overtemp_event = 1'b0;
   logic main_ov_detect = 1'b0, failure_flag = 1'b0, wd_trigger_fail = 1'b0;
   logic wd_fail_clear = 1'b0, main_ov_flag_clear = 1'b0, fail_safe_mode = 1'b0;
   wire logic spi_csn_b, spi_clk, spi_mosi, spi_miso, rep_v, soft_reset_req, reset_output_b;
   wire logic secondary_supply_on, main_overvoltage_flag, ov_mode_change_req;
   wire logic failure_outputs, wd_fail_mode_req;
   wire logic [7:0] rep;
   wire logic [1:0] reset_threshold_select;
   msh_mode_type op_mode;
   logic [7:0] s1 = 8'h00, s2 = 8'h00, exp_q[$];
   int num_errors = 0, checks_done = 0, soft_exp = 0, soft_seen = 0;

   msh_ctrl_regs i_dut (.ref_clk, .rst_b, .spi_csn_b, .spi_clk, .spi_mosi, .spi_miso,
      .restart_entry, .overtemp_event, .main_ov_detect, .main_ov_flag_clear,
      .failure_flag, .fail_safe_mode, .wd_trigger_fail, .wd_fail_clear, .op_mode,
      .soft_reset_req, .reset_output_b, .secondary_supply_on, .reset_threshold_select,
      .main_overvoltage_flag, .ov_mode_change_req, .failure_outputs, .wd_fail_mode_req);
   msh_spi_master i_mst (.ref_clk, .spi_csn_b, .spi_clk, .spi_mosi, .spi_miso, .rep_v, .rep);

   initial
   begin
      forever #10 ref_clk = ~ref_clk;
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
      checks_done++;
      if (s !== e)
      begin
         num_errors++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask

   // one frame; the expected reply is the contents before this access
   task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
      logic [7:0] o;
      o = (a == MSH_ADDR_MODE_SUPPLY) ? s1 : (a == MSH_ADDR_HW_BEHAV) ? s2 : 8'h00;
      exp_q.push_back(o);
      if (w && a == MSH_ADDR_MODE_SUPPLY && d[7:6] == 2'h3)
         soft_exp++;
      if (w && a == MSH_ADDR_MODE_SUPPLY)
         s1 = (o[7:6] == 2'h2 && d[7:6] == 2'h1) ? {2'h2, d[5:0] & 6'h1f}
                                                 : d & MSH_MODE_SUPPLY_MASK;
      if (w && a == MSH_ADDR_HW_BEHAV)
         s2 = d & MSH_HW_BEHAV_MASK;
      i_mst.xfer({w, a, d});
   endtask

   task automatic wrap_up();
      if (num_errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------
   // monitor, watchdog and tests
   // ------------------------------------------------------------
   always @(posedge ref_clk)
   begin
      if (rep_v)
         cmp("reply", exp_q.pop_front(), rep);
      if (soft_reset_req)
      begin
         soft_seen++;
         cmp("reset_out", {7'h00, s2[6]}, {7'h00, reset_output_b});
      end
   end

   initial
   begin
      #400000;
      num_errors++;
      wrap_up();
   end

   initial
   begin
      logic [31:0] r;
      r = $urandom(59);
      tick(16);
      rst_b = 1'b1;
      tick(2);
      acc(1'b0, MSH_ADDR_MODE_SUPPLY, 8'h00);
      acc(1'b1, MSH_ADDR_MODE_SUPPLY, 8'hff);
      acc(1'b1, MSH_ADDR_HW_BEHAV, 8'hff);
      acc(1'b1, 7'h05, 8'hff);
      for (int i = 0; i < 16; i++)
         acc(1'($urandom), 7'($urandom_range(3, 0)), 8'($urandom));
      acc(1'b1, MSH_ADDR_MODE_SUPPLY, 8'h9f);
      acc(1'b1, MSH_ADDR_MODE_SUPPLY, 8'h5f);
      cmp("op_mode", 8'h02, {6'h00, op_mode});
      acc(1'b1, MSH_ADDR_HW_BEHAV, 8'h61);
      cmp("force", 8'h01, {7'h00, failure_outputs});
      restart_entry = 1'b1;
      tick(1);
      restart_entry = 1'b0;
      s1 = s1 & MSH_MODE_SUPPLY_KEEP;
      s2 = s2 & MSH_HW_BEHAV_KEEP;
      cmp("force_rs", 8'h00, {7'h00, failure_outputs});
      cmp("op_rs", 8'h00, {6'h00, op_mode});
      failure_flag = 1'b1;
      tick(1);
      cmp("fail_out", 8'h01, {7'h00, failure_outputs});
      failure_flag = 1'b0;
      acc(1'b0, MSH_ADDR_MODE_SUPPLY, 8'h00);
      acc(1'b0, MSH_ADDR_HW_BEHAV, 8'h00);
      for (int c = 0; c < 4; c++)
      begin
         acc(1'b1, MSH_ADDR_MODE_SUPPLY, 8'(c * 9));
         cmp("supply", {7'h00, c != 0}, {7'h00, secondary_supply_on});
         cmp("thresh", 8'(c), {6'h00, reset_threshold_select});
      end
      fail_safe_mode = 1'b1;
      tick(1);
      cmp("supply_fs", 8'h00, {7'h00, secondary_supply_on});
      fail_safe_mode = 1'b0;
      overtemp_event = 1'b1;
      tick(1);
      overtemp_event = 1'b0;
      s1[4:3] = 2'h0;
      cmp("supply_ot", 8'h00, {7'h00, secondary_supply_on});
      for (int v = 0; v < 2; v++)
      begin
         acc(1'b1, MSH_ADDR_MODE_SUPPLY, 8'(v * 4));
         main_ov_detect = 1'b1;
         tick(1);
         main_ov_detect = 1'b0;
         cmp("ov_flag", 8'h01, {7'h00, main_overvoltage_flag});
         cmp("ov_req", 8'(v), {7'h00, ov_mode_change_req});
      end
      main_ov_flag_clear = 1'b1;
      main_ov_detect = 1'b1;
      tick(1);
      main_ov_detect = 1'b0;
      cmp("ov_set_win", 8'h01, {7'h00, main_overvoltage_flag});
      tick(1);
      main_ov_flag_clear = 1'b0;
      cmp("ov_clear", 8'h00, {7'h00, main_overvoltage_flag});
      for (int g = 0; g < 2; g++)
      begin
         acc(1'b1, MSH_ADDR_HW_BEHAV, 8'(g));
         for (int k = 0; k < 2 - g; k++)
         begin
            wd_trigger_fail = 1'b1;
            tick(1);
            wd_trigger_fail = 1'b0;
            cmp("wd_req", 8'(k == 1 || g == 1), {7'h00, wd_fail_mode_req});
            tick(1);
         end
         wd_fail_clear = 1'b1;
         tick(1);
         wd_fail_clear = 1'b0;
      end
      acc(1'b1, MSH_ADDR_MODE_SUPPLY, 8'hc0);
      acc(1'b1, MSH_ADDR_HW_BEHAV, 8'h40);
      acc(1'b1, MSH_ADDR_MODE_SUPPLY, 8'hc0);
      tick(4);
      cmp("op_soft", 8'h00, {6'h00, op_mode});
      cmp("soft_count", 8'(soft_exp), 8'(soft_seen));
      wrap_up();
   end
endmodule
`default_nettype wire
